//--- rtl/dpmc_map.vh
// Constants for the DPLL operating-mode controller
`ifndef DPMC_MAP_VH
`define DPMC_MAP_VH
// Mode select encodings, high bit then low bit
`define DPMC_SEL_FREE     2'h0
`define DPMC_SEL_REF_A    2'h1
`define DPMC_SEL_REF_B    2'h2
`define DPMC_SEL_HOLD     2'h3
// Mode status encodings
`define DPMC_MODE_FREE    3'h0
`define DPMC_MODE_EVAL    3'h1
`define DPMC_MODE_ACQ     3'h2
`define DPMC_MODE_LOCK_A  3'h3
`define DPMC_MODE_LOCK_B  3'h4
`define DPMC_MODE_HOLD    3'h5
// Reference evaluation window: 100 us at the 10 MHz clock
`define DPMC_EVAL_CYC     16'h03E8
// Frequency acquisition time: 200 us at the 10 MHz clock
`define DPMC_ACQ_CYC      16'h07D0
// Activity watchdog: reference lost after this many cycles without an edge
`define DPMC_LOSS_CYC     16'h1000
// Output divider defaults
`define DPMC_DIV_MAIN     16'h0005
`define DPMC_DIV_AUX      16'h000A
`endif

//--- rtl/dpmc_hist_mem.v
// Holdover history memory with registered read data
module dpmc_hist_mem #(
  parameter DW = 16,
  parameter AW = 3
) (
  input  wire          clk_sys_in, // System clock
  input  wire          wr_en_in,   // Write strobe
  input  wire [AW-1:0] wr_addr_in, // Write address
  input  wire [DW-1:0] wr_data_in, // Write data
  input  wire [AW-1:0] rd_addr_in, // Read address
  output reg  [DW-1:0] rd_data_out // Registered read data
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  always @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule

//--- rtl/dpmc_mode_ctrl.v
// DPLL operating-mode controller: mode machine, history, output dividers
//
// What this block does
// - Select 00 free,01 A,10 B,11 holdover
// - Jumper open manual, closed automatic
// - Automatic moves to available reference itself
// - Manual holds selected mode until select changes or its reference is lost
// - Re-requested lost reference enters evaluation
// - Evaluate, then acquire, then phase lock
// - Lock A follows reference input A
// - Lock B follows reference input B
// - Holdover steers from stored history
// - History updated only while locked
// - Free-run ignores both references
// - Both outputs divide the oscillator
// - References 8 kHz to 77.76 MHz, preset
`include "dpmc_map.vh"
module dpmc_mode_ctrl #(
  parameter        DW       = 16,
  parameter        HAW      = 3,
  parameter [15:0] DIV_MAIN = `DPMC_DIV_MAIN,
  parameter [15:0] DIV_AUX  = `DPMC_DIV_AUX,
  parameter [15:0] LOSS_CYC = `DPMC_LOSS_CYC
) (
  input  wire          clk_sys_in,              // Oscillator clock
  input  wire          srst_in,                 // Sync reset, active high
  input  wire          mode_select_low_in,      // Mode select low bit
  input  wire          mode_select_high_in,     // Mode select high bit
  input  wire          control_style_jumper_in, // 1 closed = automatic
  input  wire          reference_input_a_in,    // Reference A clock
  input  wire          reference_input_b_in,    // Reference B clock
  input  wire [DW-1:0] steer_word_in,           // Loop-filter steer word
  output reg  [DW-1:0] dac_word_out,            // Oscillator steer word
  output reg  [2:0]    mode_out,                // Current mode
  output reg           phase_ref_sel_out,       // 0 ref A, 1 ref B
  output reg           phase_ref_en_out,        // Phase detector active
  output reg           history_valid_out,       // History usable
  output reg           clock_out,               // Main divided clock
  output reg           auxiliary_clock_output_out // Aux divided clock
);
  // ****************************************
  // States
  // ****************************************
  localparam [5:0] ST_FREE = 6'h01;
  localparam [5:0] ST_EVAL = 6'h02;
  localparam [5:0] ST_ACQ  = 6'h04;
  localparam [5:0] ST_LKA  = 6'h08;
  localparam [5:0] ST_LKB  = 6'h10;
  localparam [5:0] ST_HOLD = 6'h20;
  localparam [15:0] EVAL_CYC = `DPMC_EVAL_CYC;
  localparam [15:0] ACQ_CYC  = `DPMC_ACQ_CYC;

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg  [4:0] sync1_r;
  reg  [4:0] sync2_r;
  reg  [1:0] ref_d_r;
  always @(posedge clk_sys_in) begin
    sync1_r <= {reference_input_b_in, reference_input_a_in, control_style_jumper_in,
                mode_select_high_in, mode_select_low_in};
    sync2_r <= sync1_r;
    ref_d_r <= sync2_r[4:3];
  end
  wire [1:0] sel_w  = sync2_r[1:0];
  wire       auto_w = sync2_r[2];
  wire [1:0] edge_w = sync2_r[4:3] ^ ref_d_r;

  // ****************************************
  // Reference activity monitors
  // ****************************************
  wire [1:0] ref_ok_w;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_mon
      reg [15:0] wd_r;
      always @(posedge clk_sys_in) begin
        if (srst_in) begin
          wd_r <= LOSS_CYC;
        end else if (edge_w[gi]) begin
          wd_r <= 16'h0000;
        end else if (wd_r != LOSS_CYC) begin
          wd_r <= wd_r + 16'h0001;
        end
      end
      assign ref_ok_w[gi] = (wd_r != LOSS_CYC);
    end
  endgenerate

  // ****************************************
  // Mode machine
  // ****************************************
  reg [5:0]  st_r;
  reg [5:0]  st_nxt;
  reg        tgt_r;
  reg        tgt_nxt;
  reg [15:0] tmr_r;
  reg [1:0]  sel_d_r;
  reg [1:0]  lost_r;
  wire       sel_chg_w = (sel_w != sel_d_r);
  wire       tgt_ok_w  = tgt_r ? ref_ok_w[1] : ref_ok_w[0];

  function [1:0] want_ref;
    input [1:0] s;
    begin
      want_ref = {s == `DPMC_SEL_REF_B, s == `DPMC_SEL_REF_A};
    end
  endfunction

  always @* begin
    st_nxt  = st_r;
    tgt_nxt = tgt_r;
    case (st_r)
      ST_FREE, ST_HOLD: begin
        if (auto_w && (ref_ok_w != 2'h0)) begin
          tgt_nxt = ~ref_ok_w[0];
          st_nxt  = ST_EVAL;
        end else if (!auto_w && sel_chg_w) begin
          if (want_ref(sel_w) != 2'h0) begin
            tgt_nxt = want_ref(sel_w) == 2'h2;
            st_nxt  = ST_EVAL;
          end else if (sel_w == `DPMC_SEL_HOLD && history_valid_out) begin
            st_nxt = ST_HOLD;
          end else begin
            st_nxt = ST_FREE;
          end
        end else if (!auto_w && (want_ref(sel_w) & lost_r) != 2'h0 &&
                     (want_ref(sel_w) & ref_ok_w) != 2'h0) begin
          tgt_nxt = want_ref(sel_w) == 2'h2;
          st_nxt  = ST_EVAL;
        end
      end
      ST_EVAL, ST_ACQ, ST_LKA, ST_LKB: begin
        if (!tgt_ok_w) begin
          st_nxt = history_valid_out ? ST_HOLD : ST_FREE;
        end else if (!auto_w && sel_chg_w) begin
          st_nxt = ST_FREE;
          if (want_ref(sel_w) != 2'h0) begin
            tgt_nxt = want_ref(sel_w) == 2'h2;
            st_nxt  = ST_EVAL;
          end else if (sel_w == `DPMC_SEL_HOLD && history_valid_out) begin
            st_nxt = ST_HOLD;
          end
        end else if (st_r == ST_EVAL && tmr_r == EVAL_CYC - 16'h0001) begin
          st_nxt = ST_ACQ;
        end else if (st_r == ST_ACQ && tmr_r == ACQ_CYC - 16'h0001) begin
          st_nxt = tgt_r ? ST_LKB : ST_LKA;
        end
      end
      default: st_nxt = ST_FREE;
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      st_r    <= ST_FREE;
      tgt_r   <= 1'b0;
      tmr_r   <= 16'h0000;
      sel_d_r <= 2'h0;
      lost_r  <= 2'h0;
    end else begin
      st_r    <= st_nxt;
      tgt_r   <= tgt_nxt;
      sel_d_r <= sel_w;
      tmr_r   <= (st_nxt != st_r || tgt_nxt != tgt_r) ? 16'h0000 : tmr_r + 16'h0001;
      if ((st_r == ST_EVAL || st_r == ST_ACQ || st_r == ST_LKA || st_r == ST_LKB) &&
          !tgt_ok_w) begin
        lost_r[tgt_r] <= 1'b1;
      end else if (st_nxt == ST_LKA || st_nxt == ST_LKB) begin
        lost_r[tgt_r] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Holdover history
  // ****************************************
  reg  [HAW-1:0] wptr_r;
  reg  [HAW-1:0] rptr_r;
  reg  [15:0]    hdiv_r;
  wire [DW-1:0]  hist_w;
  wire           locked_w = (st_r == ST_LKA) || (st_r == ST_LKB);
  wire           hwr_w    = locked_w && (hdiv_r == 16'h0000);

  dpmc_hist_mem #(.DW(DW), .AW(HAW)) u_hist (
    .clk_sys_in  (clk_sys_in),
    .wr_en_in    (hwr_w),
    .wr_addr_in  (wptr_r),
    .wr_data_in  (steer_word_in),
    .rd_addr_in  (rptr_r),
    .rd_data_out (hist_w)
  );

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      wptr_r            <= {HAW{1'b0}};
      rptr_r            <= {HAW{1'b0}};
      hdiv_r            <= 16'h0000;
      history_valid_out <= 1'b0;
    end else begin
      hdiv_r <= hdiv_r + 16'h0001;
      if (hwr_w) begin
        wptr_r <= wptr_r + {{(HAW-1){1'b0}}, 1'b1};
        rptr_r <= wptr_r;
        if (wptr_r == {HAW{1'b1}}) begin
          history_valid_out <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Steering and status outputs
  // ****************************************
  localparam [DW-1:0] DAC_MID = {1'b1, {(DW-1){1'b0}}};
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      dac_word_out      <= DAC_MID;
      mode_out          <= `DPMC_MODE_FREE;
      phase_ref_sel_out <= 1'b0;
      phase_ref_en_out  <= 1'b0;
    end else begin
      phase_ref_sel_out <= tgt_r;
      phase_ref_en_out  <= (st_r == ST_ACQ) || locked_w;
      case (st_r)
        ST_FREE: begin
          dac_word_out <= DAC_MID;
          mode_out     <= `DPMC_MODE_FREE;
        end
        ST_HOLD: begin
          dac_word_out <= hist_w;
          mode_out     <= `DPMC_MODE_HOLD;
        end
        ST_EVAL: begin
          dac_word_out <= DAC_MID;
          mode_out     <= `DPMC_MODE_EVAL;
        end
        ST_ACQ: begin
          dac_word_out <= steer_word_in;
          mode_out     <= `DPMC_MODE_ACQ;
        end
        ST_LKA: begin
          dac_word_out <= steer_word_in;
          mode_out     <= `DPMC_MODE_LOCK_A;
        end
        ST_LKB: begin
          dac_word_out <= steer_word_in;
          mode_out     <= `DPMC_MODE_LOCK_B;
        end
        default: begin
          dac_word_out <= DAC_MID;
          mode_out     <= `DPMC_MODE_FREE;
        end
      endcase
    end
  end

  // ****************************************
  // Output dividers
  // ****************************************
  reg [15:0] cnt_m_r;
  reg [15:0] cnt_a_r;
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      cnt_m_r                    <= 16'h0000;
      cnt_a_r                    <= 16'h0000;
      clock_out                  <= 1'b0;
      auxiliary_clock_output_out <= 1'b0;
    end else begin
      cnt_m_r <= (cnt_m_r == DIV_MAIN - 16'h0001) ? 16'h0000 : cnt_m_r + 16'h0001;
      cnt_a_r <= (cnt_a_r == DIV_AUX - 16'h0001) ? 16'h0000 : cnt_a_r + 16'h0001;
      if (cnt_m_r == DIV_MAIN - 16'h0001) begin
        clock_out <= ~clock_out;
      end
      if (cnt_a_r == DIV_AUX - 16'h0001) begin
        auxiliary_clock_output_out <= ~auxiliary_clock_output_out;
      end
    end
  end
endmodule

//--- tb/dpmc_mode_ctrl_monitor.sv
// Port checker for the DPLL mode controller
`include "dpmc_map.vh"
module dpmc_mode_ctrl_monitor #(
  parameter [15:0] DIV_MAIN = 16'h0005,
  parameter [15:0] DIV_AUX  = 16'h000A
) (
  input wire        clk_sys_in,              // Clock
  input wire        srst_in,                 // Reset
  input wire        mode_select_low_in,      // Select low
  input wire        mode_select_high_in,     // Select high
  input wire        control_style_jumper_in, // Jumper
  input wire [15:0] dac_word_out,            // Steer word
  input wire [2:0]  mode_out,                // Mode
  input wire        phase_ref_sel_out,       // Phase ref
  input wire        history_valid_out,       // History
  input wire        clock_out,               // Main clock
  input wire        auxiliary_clock_output_out // Aux clock
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  reg [15:0] cnt_m_r;
  reg [15:0] cnt_x_r;
  reg        prv_m_r;
  reg        prv_x_r;
  reg        seen_m_r;
  reg        seen_x_r;
  wire       chg_m = clock_out != prv_m_r;
  wire       chg_x = auxiliary_clock_output_out != prv_x_r;
  // Half-period counters
  always @(posedge clk_sys_in) begin
    prv_m_r  <= clock_out;
    prv_x_r  <= auxiliary_clock_output_out;
    cnt_m_r  <= chg_m ? 16'h0000 : cnt_m_r + 16'h0001;
    cnt_x_r  <= chg_x ? 16'h0000 : cnt_x_r + 16'h0001;
    seen_m_r <= !srst_in && (seen_m_r || chg_m);
    seen_x_r <= !srst_in && (seen_x_r || chg_x);
  end
  sequence s_enter_lock;
    (mode_out == `DPMC_MODE_LOCK_A || mode_out == `DPMC_MODE_LOCK_B)
      && $past(mode_out) != mode_out;
  endsequence
  sequence s_enter_acq;
    mode_out == `DPMC_MODE_ACQ && $past(mode_out) != mode_out;
  endsequence
  sequence s_manual_free;
    (!control_style_jumper_in && !mode_select_high_in && !mode_select_low_in
      && mode_out == `DPMC_MODE_FREE) [*6];
  endsequence
  property p_sel_a; mode_out == `DPMC_MODE_LOCK_A |-> !phase_ref_sel_out; endproperty
  property p_sel_b; mode_out == `DPMC_MODE_LOCK_B |-> phase_ref_sel_out; endproperty
  property p_lock_order; s_enter_lock |-> $past(mode_out) == `DPMC_MODE_ACQ; endproperty
  property p_acq_order; s_enter_acq |-> $past(mode_out) == `DPMC_MODE_EVAL; endproperty
  property p_free_dac; mode_out == `DPMC_MODE_FREE |-> dac_word_out == 16'h8000; endproperty
  property p_hold_hist; mode_out == `DPMC_MODE_HOLD |-> history_valid_out; endproperty
  property p_manual_free; s_manual_free |=> mode_out == `DPMC_MODE_FREE; endproperty
  property p_div_main; chg_m && seen_m_r |-> cnt_m_r == DIV_MAIN - 16'h0001; endproperty
  property p_div_aux; chg_x && seen_x_r |-> cnt_x_r == DIV_AUX - 16'h0001; endproperty
  a_sel_a: assert property (p_sel_a) else $error("lock A uses wrong phase ref");
  a_sel_b: assert property (p_sel_b) else $error("lock B uses wrong phase ref");
  a_lock_order: assert property (p_lock_order) else $error("lock not after acquire");
  a_acq_order: assert property (p_acq_order) else $error("acquire not after eval");
  a_free_dac: assert property (p_free_dac) else $error("free-run steer not centred");
  a_hold_hist: assert property (p_hold_hist) else $error("holdover without history");
  a_manual_free: assert property (p_manual_free) else $error("manual free-run left");
  a_div_main: assert property (p_div_main) else $error("main clock half period");
  a_div_aux: assert property (p_div_aux) else $error("aux clock half period");
endmodule
bind dpmc_mode_ctrl dpmc_mode_ctrl_monitor #(.DIV_MAIN(DIV_MAIN), .DIV_AUX(DIV_AUX)) i_mon (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .mode_select_low_in(mode_select_low_in),
  .mode_select_high_in(mode_select_high_in), .control_style_jumper_in(control_style_jumper_in),
  .dac_word_out(dac_word_out), .mode_out(mode_out), .phase_ref_sel_out(phase_ref_sel_out),
  .history_valid_out(history_valid_out), .clock_out(clock_out),
  .auxiliary_clock_output_out(auxiliary_clock_output_out));

//--- tb/dpmc_host_model.sv
// Host-side model: select pins, jumper and reference clocks
module dpmc_host_model (
  input  wire       clk_sys_in,   // Clock
  input  wire [1:0] req_in,       // Requested mode
  input  wire       auto_in,      // Jumper closed
  input  wire       ref_a_on_in,  // Reference A alive
  input  wire       ref_b_on_in,  // Reference B alive
  output reg        sel_low_out,  // Select low
  output reg        sel_high_out, // Select high
  output reg        jumper_out,   // Jumper
  output reg        ref_a_out,    // Reference A
  output reg        ref_b_out     // Reference B
);
  timeunit 1ns;
  timeprecision 1ns;
  reg div_r = 1'b0;
  initial {sel_high_out, sel_low_out, jumper_out, ref_a_out, ref_b_out} = 5'h00;
  // select order, fixed rate, silent when lost
  always @(negedge clk_sys_in) begin
    div_r <= ~div_r;
    {sel_high_out, sel_low_out} <= req_in;
    jumper_out <= auto_in;
    if (ref_a_on_in && div_r) ref_a_out <= ~ref_a_out;
    if (ref_b_on_in && div_r) ref_b_out <= ~ref_b_out;
  end
endmodule

//--- tb/test_dpmc_mode_ctrl.sv
// Testbench for the DPLL mode controller
`include "dpmc_map.vh"
module test_dpmc_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk_sys_in = 1'b0, srst_in = 1'b1, auto = 1'b0, a_on = 1'b0, b_on = 1'b0;
  localparam [15:0] AUX_DIV = 16'h0008;
  reg [1:0] req = 2'h0;
  wire lo, hi, jmp, ra, rb, psel, pen, hv, ck, ack;
  wire [15:0] dac;
  wire [2:0] mode;
  integer error_cnt = 0, checks_done = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  dpmc_host_model i_host (.clk_sys_in(clk_sys_in), .req_in(req), .auto_in(auto),
    .ref_a_on_in(a_on), .ref_b_on_in(b_on), .sel_low_out(lo), .sel_high_out(hi),
    .jumper_out(jmp), .ref_a_out(ra), .ref_b_out(rb));
  dpmc_mode_ctrl #(.LOSS_CYC(16'h0040), .DIV_AUX(AUX_DIV)) i_dut (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .mode_select_low_in(lo), .mode_select_high_in(hi),
    .control_style_jumper_in(jmp), .reference_input_a_in(ra), .reference_input_b_in(rb),
    .steer_word_in(16'h1234), .dac_word_out(dac), .mode_out(mode), .phase_ref_sel_out(psel),
    .phase_ref_en_out(pen), .history_valid_out(hv), .clock_out(ck),
    .auxiliary_clock_output_out(ack));
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wait_mode(input [2:0] m, input integer lim);
    integer i;
    begin
      for (i = 0; i < lim && mode !== m; i = i + 1) @(negedge clk_sys_in);
      chk({13'h0000, mode}, {13'h0000, m});
      if (mode !== m) tally_and_finish;
    end
  endtask
  task t_lock(input [1:0] s, input [2:0] lk, input b);
    begin
      req = s;
      wait_mode(`DPMC_MODE_EVAL, 10);
      wait_mode(`DPMC_MODE_ACQ, 1010);
      chk({15'h0000, pen}, 16'h0001);
      wait_mode(lk, 2010);
      chk({15'h0000, psel}, {15'h0000, b});
      chk(dac, 16'h1234);
    end
  endtask
  task t_loss_and_refuse;
    begin
      b_on = 1'b0;
      wait_mode(`DPMC_MODE_FREE, 90);
      chk({15'h0000, hv}, 16'h0000);
      req = `DPMC_SEL_HOLD;
      repeat (12) @(negedge clk_sys_in);
      chk({13'h0000, mode}, {13'h0000, `DPMC_MODE_FREE});
    end
  endtask
  task t_rerequest;
    begin
      req = `DPMC_SEL_REF_B;
      wait_mode(`DPMC_MODE_EVAL, 10);
      wait_mode(`DPMC_MODE_FREE, 10);
      b_on = 1'b1;
      wait_mode(`DPMC_MODE_EVAL, 20);
      req = `DPMC_SEL_FREE;
      wait_mode(`DPMC_MODE_FREE, 10);
      repeat (300) @(negedge clk_sys_in);
      chk({13'h0000, mode}, {13'h0000, `DPMC_MODE_FREE});
      chk(dac, 16'h8000);
    end
  endtask
  task t_auto;
    begin
      auto = 1'b1;
      wait_mode(`DPMC_MODE_EVAL, 10);
      wait_mode(`DPMC_MODE_ACQ, 1010);
      wait_mode(`DPMC_MODE_LOCK_A, 2010);
    end
  endtask
  task t_divider(input [15:0] half, input aux_sel);
    integer i;
    reg     lvl;
    begin
      lvl = aux_sel ? ack : ck;
      for (i = 0; i < 40 && (aux_sel ? ack : ck) === lvl; i = i + 1) @(negedge clk_sys_in);
      lvl = aux_sel ? ack : ck;
      for (i = 0; i < 40 && (aux_sel ? ack : ck) === lvl; i = i + 1) @(negedge clk_sys_in);
      chk(i[15:0], half);
    end
  endtask
  initial begin
    a_on = 1'b1;
    b_on = 1'b1;
    repeat (8) @(negedge clk_sys_in);
    srst_in = 1'b0;
    chk({13'h0000, mode}, {13'h0000, `DPMC_MODE_FREE});
    chk(dac, 16'h8000);
    t_divider(`DPMC_DIV_MAIN, 1'b0);
    t_divider(AUX_DIV, 1'b1);
    t_lock(`DPMC_SEL_REF_A, `DPMC_MODE_LOCK_A, 1'b0);
    t_lock(`DPMC_SEL_REF_B, `DPMC_MODE_LOCK_B, 1'b1);
    t_loss_and_refuse;
    t_rerequest;
    t_auto;
    tally_and_finish;
  end
endmodule
